// ### bench/mwd_rx_src.sv
`timescale 1ns/1ns

module mwd_rx_src (
    input  wire logic       clk,      // Clock
    output logic            rx_valid, // Byte valid
    output logic            rx_sof,   // First byte
    output logic            rx_eof,   // Last byte
    output logic            rx_good,  // Frame checks passed
    output logic      [7:0] rx_data   // Byte
);
    initial begin
        rx_valid = 1'b0;
        rx_sof   = 1'b0;
        rx_eof   = 1'b0;
        rx_good  = 1'b0;
        rx_data  = 8'h00;
    end

    // Idle cycles between bytes model a slow link; data never holds when idle
    task automatic send(input logic [7:0] b[$], input logic good, input int gap);
        for (int i = 0; i < b.size(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_sof   <= (i == 0);
            rx_eof   <= (i == b.size() - 1);
            rx_good  <= good;
            rx_data  <= b[i];
            repeat (gap) begin
                @(posedge clk);
                rx_valid <= 1'b0;
                rx_data  <= ~b[i];
            end
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b[b.size() - 1];
    endtask
endmodule

// ### bench/mwd_wake_detect_properties.sv
`timescale 1ns/1ns

module mwd_wake_detect_properties (
    input wire logic        clk,        // Clock
    input wire logic        rst,        // Synchronous reset
    input wire logic [3:0]  addr,       // Register index
    input wire logic        wr_en,      // Write strobe
    input wire logic        rd_en,      // Read strobe
    input wire logic [31:0] rd_data,    // Read data
    input wire logic        rx_valid,   // Receive byte valid
    input wire logic        rx_eof,     // Last byte of frame
    input wire logic        rx_good,    // Frame good
    input wire logic        power_save, // Power-saving mode
    input wire logic        wake_out,   // Wake request
    input wire logic        irq         // Interrupt
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    wire good_end = rx_valid && rx_eof && rx_good;
    wire bad_end  = rx_valid && rx_eof && !rx_good;
    wire en_wr    = wr_en && (addr == 4'hF);
    wire clr_wr   = wr_en && ((addr == 4'hE) || (addr == 4'hF));

    rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 32'h0)
        else $error("read data not idle");
    port_unread_a: assert property (rd_en && addr == 4'hB |=> rd_data == 32'h0)
        else $error("filter port readable");
    wake_power_a: assert property (wake_out |-> $past(power_save))
        else $error("wake outside power save");
    wake_cause_a: assert property (wake_out |-> $past(good_end, 2))
        else $error("wake without good frame end");
    bad_silent_a: assert property (bad_end |-> ##2 !wake_out)
        else $error("wake after bad frame");
    wake_pulse_a: assert property (wake_out |=> !wake_out)
        else $error("wake longer than one cycle");
    irq_rise_a: assert property ($rose(irq) |-> $past(good_end, 2) || $past(en_wr))
        else $error("interrupt without cause");
    irq_hold_a: assert property ($fell(irq) |-> $past(clr_wr) || $past(clr_wr, 2))
        else $error("interrupt dropped by itself");
    reset_quiet_a: assert property ($fell(rst) |-> !wake_out && !irq && rd_data == 32'h0)
        else $error("outputs not clear after reset");

    cover property (wake_out);
    cover property ($rose(irq));
    cover property (rd_en && addr == 4'hC);
endmodule

bind mwd_wake_detect mwd_wake_detect_properties chk (
    .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .rx_valid(rx_valid), .rx_eof(rx_eof), .rx_good(rx_good),
    .power_save(power_save), .wake_out(wake_out), .irq(irq));

// ### bench/mwd_wake_detect_tb.sv
`timescale 1ns/1ns

module mwd_wake_detect_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [31:0] rd_data;
    logic        rx_valid, rx_sof, rx_eof, rx_good;
    logic [7:0]  rx_data;
    logic [47:0] station_addr = 48'h0;
    logic        power_save = 1'b0;
    logic        wake_out, irq;
    logic        rd_seen = 1'b0;
    logic [31:0] exp_q[$];
    int          err_total = 0, n_tests = 0, wake_n = 0, exp_wake = 0, seed = 1;

    mwd_wake_detect DUT (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_valid(rx_valid),
        .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_good(rx_good), .rx_data(rx_data),
        .station_addr(station_addr), .power_save(power_save),
        .wake_out(wake_out), .irq(irq));
    mwd_rx_src src (.clk(clk), .rx_valid(rx_valid), .rx_sof(rx_sof),
        .rx_eof(rx_eof), .rx_good(rx_good), .rx_data(rx_data));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // Frame: first byte, random filler, optional wake packet; w = wake expected
    task automatic frame(input logic [7:0] b0, input logic mp, input logic good, input int w);
        logic [7:0] q[$];
        q.push_back(b0);
        repeat (5) q.push_back(8'($random(seed)));
        if (mp) begin
            repeat (6) q.push_back(8'hFF);
            repeat (16) for (int k = 0; k < 6; k++) q.push_back(station_addr[8*k +: 8]);
        end
        src.send(q, good, $random(seed) & 1);
        repeat (4) @(posedge clk);
        exp_wake += w;
        check("wake_out count", 32'(exp_wake), 32'(wake_n));
    endtask

    // Read answers are compared in the cycle they stand
    always @(posedge clk) begin
        if (rd_seen)
            check("rd_data", exp_q.pop_front(), rd_data);
        if (wake_out)
            wake_n++;
        rd_seen <= rd_en;
    end

    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst          <= 1'b0;
        // Sync byte as first address byte would never leave the hunt
        station_addr <= 48'({$random(seed), $random(seed)}) & 48'hFFFF_FFFF_FF7F;
        power_save   <= 1'b1;
        repeat (2) @(posedge clk);
        exp_q.delete();
        for (int a = 0; a < 16; a++) rd(4'(a), 32'h0);
        for (int i = 0; i < 8; i++) wr(4'hB, (i == 4) ? 32'h0000_00A5 : 32'h0);
        wr(4'hB, 32'h0000_0001);
        rd(4'hB, 32'h0);
        frame(8'hA5, 1'b0, 1'b1, 0);
        rd(4'hC, 32'h0);
        wr(4'hC, 32'h0000_0004);
        frame(8'hA5, 1'b0, 1'b1, 1);
        rd(4'hC, 32'h0000_0044);
        frame(8'h37, 1'b0, 1'b1, 0);
        rd(4'hC, 32'h0000_0044);
        wr(4'hC, 32'h0000_0044);
        rd(4'hC, 32'h0000_0004);
        wr(4'hC, 32'h0);
        frame(8'h01, 1'b1, 1'b1, 0);
        rd(4'hC, 32'h0);
        wr(4'hC, 32'h0000_0002);
        frame(8'h01, 1'b1, 1'b0, 0);
        rd(4'hC, 32'h0000_0002);
        frame(8'h01, 1'b1, 1'b1, 1);
        rd(4'hC, 32'h0000_0022);
        wr(4'hC, 32'h0000_0200);
        wr(4'hF, 32'h0000_0004);
        frame(8'h03, 1'b0, 1'b1, 0);
        check("irq", 32'h0, {31'h0, irq});
        frame(8'h02, 1'b0, 1'b1, 1);
        check("irq", 32'h1, {31'h0, irq});
        rd(4'hC, 32'h0000_0220);
        rd(4'hD, 32'h0000_0007);
        wr(4'hF, 32'h0000_0007);
        repeat (3) @(posedge clk);
        check("irq", 32'h1, {31'h0, irq});
        wr(4'hE, 32'h0000_0007);
        repeat (3) @(posedge clk);
        check("irq", 32'h0, {31'h0, irq});
        power_save <= 1'b0;
        frame(8'h02, 1'b0, 1'b1, 0);
        rd(4'hD, 32'h0);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst        <= 1'b0;
        power_save <= 1'b1;
        repeat (2) @(posedge clk);
        rd(4'hC, 32'h0);
        // Mask in word 3, sum in word 7: a stale pointer swaps their roles
        for (int i = 0; i < 8; i++) wr(4'hB, (i == 7) ? 32'h0000_00A5 : 32'(i == 3));
        wr(4'hC, 32'h0000_0004);
        frame(8'hA5, 1'b0, 1'b1, 1);
        rd(4'hC, 32'h0000_0044);
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule

// ### core/mwd_magic_detect.sv
`timescale 1ns/1ns

module mwd_magic_detect (
    input  wire logic        clk,          // Clock
    input  wire logic        rst,          // Synchronous reset
    input  wire logic        take,         // Byte of a frame accepted
    input  wire logic        sof,          // Byte is first of frame
    input  wire logic [7:0]  data,         // Received byte
    input  wire logic [47:0] station_addr, // Own address, byte 0 first
    output logic             hit           // Wake packet seen in frame
);

    typedef enum logic [0:0] {MP_HUNT, MP_ADDR} mwd_mp_state_e;

    mwd_mp_state_e state;
    mwd_mp_state_e next_state;
    logic [2:0]    ff_cnt;
    logic [2:0]    next_ff_cnt;
    logic [2:0]    bpos;
    logic [2:0]    next_bpos;
    logic [3:0]    rep;
    logic [3:0]    next_rep;
    logic          next_hit;

    function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] i);
        addr_byte = a[{i, 3'b000} +: 8];
    endfunction

    always_comb begin
        // A new frame restarts the search from scratch
        next_state  = sof ? MP_HUNT : state;
        next_ff_cnt = sof ? mwd_pkg::SYNC_NONE : ff_cnt;
        next_bpos   = sof ? mwd_pkg::ADDR_FIRST : bpos;
        next_rep    = sof ? mwd_pkg::REP_FIRST : rep;
        next_hit    = sof ? 1'b0 : hit;
        case (next_state)
            MP_HUNT: begin
                if (data == mwd_pkg::SYNC_BYTE) begin
                    if (next_ff_cnt != mwd_pkg::SYNC_LEN) begin
                        next_ff_cnt = next_ff_cnt + mwd_pkg::SYNC_ONE;
                    end
                end else if (next_ff_cnt == mwd_pkg::SYNC_LEN &&
                             data == addr_byte(station_addr, mwd_pkg::ADDR_FIRST)) begin
                    next_state  = MP_ADDR;
                    next_bpos   = mwd_pkg::ADDR_STEP;
                    next_rep    = mwd_pkg::REP_FIRST;
                    next_ff_cnt = mwd_pkg::SYNC_NONE;
                end else begin
                    next_ff_cnt = mwd_pkg::SYNC_NONE;
                end
            end
            MP_ADDR: begin
                if (data == addr_byte(station_addr, next_bpos)) begin
                    if (next_bpos == mwd_pkg::ADDR_LAST) begin
                        next_bpos = mwd_pkg::ADDR_FIRST;
                        if (next_rep == mwd_pkg::REP_LAST) begin
                            next_hit   = 1'b1;
                            next_state = MP_HUNT;
                        end else begin
                            next_rep = next_rep + mwd_pkg::REP_STEP;
                        end
                    end else begin
                        next_bpos = next_bpos + mwd_pkg::ADDR_STEP;
                    end
                end else begin
                    // Broken copy: a sync byte may open a fresh run
                    next_state  = MP_HUNT;
                    next_ff_cnt = (data == mwd_pkg::SYNC_BYTE) ? mwd_pkg::SYNC_ONE
                                                              : mwd_pkg::SYNC_NONE;
                end
            end
            default: begin
                next_state = MP_HUNT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state  <= MP_HUNT;
            ff_cnt <= mwd_pkg::SYNC_NONE;
            bpos   <= mwd_pkg::ADDR_FIRST;
            rep    <= mwd_pkg::REP_FIRST;
            hit    <= 1'b0;
        end else if (take) begin
            state  <= next_state;
            ff_cnt <= next_ff_cnt;
            bpos   <= next_bpos;
            rep    <= next_rep;
            hit    <= next_hit;
        end
    end

endmodule

// ### core/mwd_pkg.sv
package mwd_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_FILTER_PORT = 4'hB;
    localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 4'hC;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS  = 4'hD;
    localparam logic [ADDR_W-1:0] OFS_INT_CLEAR   = 4'hE;
    localparam logic [ADDR_W-1:0] OFS_INT_ENABLE  = 4'hF;

    // Control and status field positions
    localparam int BIT_UNICAST_EN  = 9;
    localparam int BIT_FRAME_SEEN  = 6;
    localparam int BIT_PACKET_SEEN = 5;
    localparam int BIT_FRAME_EN    = 2;
    localparam int BIT_PACKET_EN   = 1;

    // Reset values
    localparam logic [DATA_W-1:0] FILTER_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO    = 32'h0000_0000;

    // Filter store and its write pointer
    localparam int          FILTER_WORDS = 8;
    localparam int          PTR_W        = 3;
    localparam logic [2:0]  PTR_FIRST    = 3'h0;
    localparam logic [2:0]  PTR_LAST     = 3'h7;
    localparam logic [2:0]  PTR_STEP     = 3'h1;

    // Byte-mask matching: masks in words 0..3, check sums in words 4..7
    localparam int          MASK_FILTERS = 4;
    localparam int          SUM_W        = 16;
    localparam int          POS_W        = 6;
    localparam logic [5:0]  POS_FIRST    = 6'h00;
    localparam logic [5:0]  POS_STEP     = 6'h01;
    localparam logic [5:0]  POS_SPAN     = 6'h20;
    localparam logic [15:0] SUM_ZERO     = 16'h0000;
    localparam logic [7:0]  BYTE_PAD     = 8'h00;

    // Destination address group bit
    localparam int BIT_GROUP = 0;

    // Interrupt status layout
    localparam int INT_W       = 3;
    localparam int INT_FRAME   = 0;
    localparam int INT_PACKET  = 1;
    localparam int INT_UNICAST = 2;
    localparam logic [INT_W-1:0] INT_RESET = 3'h0;

    // Wake packet: sync run then station address repeated
    localparam logic [7:0] SYNC_BYTE     = 8'hFF;
    localparam logic [2:0] SYNC_LEN      = 3'h6;
    localparam logic [2:0] SYNC_ONE      = 3'h1;
    localparam logic [2:0] SYNC_NONE     = 3'h0;
    localparam logic [2:0] ADDR_FIRST    = 3'h0;
    localparam logic [2:0] ADDR_LAST     = 3'h5;
    localparam logic [2:0] ADDR_STEP     = 3'h1;
    localparam logic [3:0] REP_FIRST     = 4'h0;
    localparam logic [3:0] REP_LAST      = 4'hF;
    localparam logic [3:0] REP_STEP      = 4'h1;

endpackage

// ### core/mwd_wake_detect.sv
// Function
// R1: After reset first filter write hits word 0
// R2: Write pointer wraps to word 0 after eight
// R3: Filter port write-only, 32 bits, reads zero
// R4: Unicast enable wakes on global unicast frame
// R5: Destination bit 0 clear means global unicast
// R6: Valid wake frame sets wake frame flag
// R7: Valid wake packet sets wake packet flag
// R8: Frame enable turns on filter-based detection
// R9: Packet enable turns on wake packet detection
// R10: Seen flags sticky until reset or clear
`timescale 1ns/1ns

module mwd_wake_detect (
    input  wire logic        clk,          // Clock, 100 MHz
    input  wire logic        rst,          // Synchronous reset, active high
    input  wire logic [3:0]  addr,         // Register index
    input  wire logic [31:0] wr_data,      // Write data
    input  wire logic        wr_en,        // Write strobe
    input  wire logic        rd_en,        // Read strobe
    output logic      [31:0] rd_data,      // Read data, cycle after strobe
    input  wire logic        rx_valid,     // Receive byte valid
    input  wire logic        rx_sof,       // First byte of frame
    input  wire logic        rx_eof,       // Last byte of frame
    input  wire logic        rx_good,      // Frame passed checks, with eof
    input  wire logic [7:0]  rx_data,      // Receive byte
    input  wire logic [47:0] station_addr, // Own address, byte 0 first
    input  wire logic        power_save,   // MAC is in power-saving mode
    output logic             wake_out,     // Wake request pulse
    output logic             irq           // Interrupt, level
);

    logic [31:0]                       filter_word [mwd_pkg::FILTER_WORDS];
    logic [mwd_pkg::PTR_W-1:0]         wr_ptr;
    logic                              unicast_wake_en;
    logic                              wake_frame_en;
    logic                              wake_packet_en;
    logic                              wake_frame_seen;
    logic                              wake_packet_seen;
    logic [mwd_pkg::INT_W-1:0]         int_status;
    logic [mwd_pkg::INT_W-1:0]         int_enable;
    logic [mwd_pkg::INT_W-1:0]         next_int_status;
    logic [mwd_pkg::INT_W-1:0]         next_int_enable;
    logic [mwd_pkg::INT_W-1:0]         event_vec;
    logic                              in_frame;
    logic                              byte_take;
    logic [mwd_pkg::POS_W-1:0]         pos;
    logic [mwd_pkg::POS_W-1:0]         cur_pos;
    logic [mwd_pkg::SUM_W-1:0]         mask_sum [mwd_pkg::MASK_FILTERS];
    logic [mwd_pkg::MASK_FILTERS-1:0]  mask_match;
    logic                              dest_unicast;
    logic                              frame_done;
    logic                              packet_hit;
    logic                              frame_evt;
    logic                              packet_evt;
    logic                              unicast_evt;
    logic                              wr_filter;
    logic                              wr_ctrl;
    logic                              wr_clear;
    logic                              wr_enable;

    function automatic logic reg_hit(input logic        strobe,
                                     input logic [3:0]  a,
                                     input logic [3:0]  ofs);
        reg_hit = strobe && (a == ofs);
    endfunction

    function automatic logic [31:0] read_mux(input logic [3:0] a,
                                             input logic       u_en,
                                             input logic       f_seen,
                                             input logic       p_seen,
                                             input logic       f_en,
                                             input logic       p_en,
                                             input logic [2:0] ist,
                                             input logic [2:0] ien);
        read_mux = mwd_pkg::READ_ZERO;
        case (a)
            mwd_pkg::OFS_CTRL_STATUS: begin
                read_mux[mwd_pkg::BIT_UNICAST_EN]  = u_en;
                read_mux[mwd_pkg::BIT_FRAME_SEEN]  = f_seen;
                read_mux[mwd_pkg::BIT_PACKET_SEEN] = p_seen;
                read_mux[mwd_pkg::BIT_FRAME_EN]    = f_en;
                read_mux[mwd_pkg::BIT_PACKET_EN]   = p_en;
            end
            mwd_pkg::OFS_INT_STATUS: begin
                read_mux[mwd_pkg::INT_W-1:0] = ist;
            end
            mwd_pkg::OFS_INT_ENABLE: begin
                read_mux[mwd_pkg::INT_W-1:0] = ien;
            end
            default: begin
                read_mux = mwd_pkg::READ_ZERO;
            end
        endcase
    endfunction

    assign wr_filter = reg_hit(wr_en, addr, mwd_pkg::OFS_FILTER_PORT);
    assign wr_ctrl   = reg_hit(wr_en, addr, mwd_pkg::OFS_CTRL_STATUS);
    assign wr_clear  = reg_hit(wr_en, addr, mwd_pkg::OFS_INT_CLEAR);
    assign wr_enable = reg_hit(wr_en, addr, mwd_pkg::OFS_INT_ENABLE);

    // R1: pointer starts at word 0
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= mwd_pkg::PTR_FIRST;
        end else if (wr_filter) begin
            // R2: wrap after the eighth word
            if (wr_ptr == mwd_pkg::PTR_LAST) begin
                wr_ptr <= mwd_pkg::PTR_FIRST;
            end else begin
                wr_ptr <= wr_ptr + mwd_pkg::PTR_STEP;
            end
        end
    end

    // R1: store write at current pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < mwd_pkg::FILTER_WORDS; i++) begin
                filter_word[i] <= mwd_pkg::FILTER_RESET;
            end
        end else if (wr_filter) begin
            filter_word[wr_ptr] <= wr_data;
        end
    end

    // Enable bits of the control word
    always_ff @(posedge clk) begin
        if (rst) begin
            unicast_wake_en <= 1'b0;
            wake_frame_en   <= 1'b0;
            wake_packet_en  <= 1'b0;
        end else if (wr_ctrl) begin
            unicast_wake_en <= wr_data[mwd_pkg::BIT_UNICAST_EN];
            wake_frame_en   <= wr_data[mwd_pkg::BIT_FRAME_EN];
            wake_packet_en  <= wr_data[mwd_pkg::BIT_PACKET_EN];
        end
    end

    // Bytes outside a frame are ignored
    assign byte_take = rx_valid && (rx_sof || in_frame);
    assign cur_pos   = rx_sof ? mwd_pkg::POS_FIRST : pos;

    always_ff @(posedge clk) begin
        if (rst) begin
            in_frame <= 1'b0;
        end else if (byte_take) begin
            in_frame <= !rx_eof;
        end
    end

    // Position saturates past the masked span
    always_ff @(posedge clk) begin
        if (rst) begin
            pos <= mwd_pkg::POS_FIRST;
        end else if (byte_take) begin
            if (cur_pos == mwd_pkg::POS_SPAN) begin
                pos <= cur_pos;
            end else begin
                pos <= cur_pos + mwd_pkg::POS_STEP;
            end
        end
    end

    // R5: group bit of first destination byte
    always_ff @(posedge clk) begin
        if (rst) begin
            dest_unicast <= 1'b0;
        end else if (byte_take && rx_sof) begin
            dest_unicast <= !rx_data[mwd_pkg::BIT_GROUP];
        end
    end

    // R8: sum of masked bytes per filter, compared to its check word
    generate
        for (genvar k = 0; k < mwd_pkg::MASK_FILTERS; k++) begin : g_mask
            logic                      mask_bit;
            logic [mwd_pkg::SUM_W-1:0] base_sum;

            assign mask_bit = (cur_pos < mwd_pkg::POS_SPAN) &&
                              filter_word[k][cur_pos[4:0]];
            assign base_sum = rx_sof ? mwd_pkg::SUM_ZERO : mask_sum[k];

            always_ff @(posedge clk) begin
                if (rst) begin
                    mask_sum[k] <= mwd_pkg::SUM_ZERO;
                end else if (byte_take) begin
                    mask_sum[k] <= base_sum +
                                   (mask_bit ? {mwd_pkg::BYTE_PAD, rx_data}
                                             : mwd_pkg::SUM_ZERO);
                end
            end

            // An all-zero mask leaves that filter unused
            assign mask_match[k] = (filter_word[k] != mwd_pkg::FILTER_RESET) &&
                (mask_sum[k] == filter_word[k + mwd_pkg::MASK_FILTERS][mwd_pkg::SUM_W-1:0]);
        end
    endgenerate

    // R9: wake packet search runs on every frame
    mwd_magic_detect u_magic (
        .clk          (clk),
        .rst          (rst),
        .take         (byte_take),
        .sof          (rx_sof),
        .data         (rx_data),
        .station_addr (station_addr),
        .hit          (packet_hit)
    );

    // Verdicts settle one cycle after the last byte
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_done <= 1'b0;
        end else begin
            frame_done <= byte_take && rx_eof && rx_good;
        end
    end

    // R8: filter verdict counts only when enabled
    assign frame_evt   = frame_done && wake_frame_en && (|mask_match);
    // R9: packet verdict counts only when enabled
    assign packet_evt  = frame_done && wake_packet_en && packet_hit;
    // R4: unicast wake only while asleep
    assign unicast_evt = frame_done && unicast_wake_en && dest_unicast && power_save;

    // R6: frame flag, set beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_frame_seen <= 1'b0;
        end else begin
            // R10: held until cleared by writing one
            wake_frame_seen <= frame_evt ||
                (wake_frame_seen && !(wr_ctrl && wr_data[mwd_pkg::BIT_FRAME_SEEN]));
        end
    end

    // R7: packet flag, set beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_packet_seen <= 1'b0;
        end else begin
            // R10: held until cleared by writing one
            wake_packet_seen <= packet_evt ||
                (wake_packet_seen && !(wr_ctrl && wr_data[mwd_pkg::BIT_PACKET_SEEN]));
        end
    end

    // R4: leave power saving on any enabled wake event
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_out <= 1'b0;
        end else begin
            wake_out <= power_save && (frame_evt || packet_evt || unicast_evt);
        end
    end

    // Interrupt status: set wins over clear
    always_comb begin
        event_vec                       = mwd_pkg::INT_RESET;
        event_vec[mwd_pkg::INT_FRAME]   = frame_evt;
        event_vec[mwd_pkg::INT_PACKET]  = packet_evt;
        event_vec[mwd_pkg::INT_UNICAST] = unicast_evt;
        next_int_status = event_vec |
            (int_status & ~(wr_clear ? wr_data[mwd_pkg::INT_W-1:0] : mwd_pkg::INT_RESET));
        next_int_enable = wr_enable ? wr_data[mwd_pkg::INT_W-1:0] : int_enable;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            int_status <= mwd_pkg::INT_RESET;
            int_enable <= mwd_pkg::INT_RESET;
        end else begin
            int_status <= next_int_status;
            int_enable <= next_int_enable;
        end
    end

    // Uses next values so the line tracks status without extra lag
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_int_status & next_int_enable);
        end
    end

    // R3: filter port and clear register read as zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= mwd_pkg::READ_ZERO;
        end else if (rd_en) begin
            rd_data <= read_mux(addr, unicast_wake_en, wake_frame_seen,
                                wake_packet_seen, wake_frame_en, wake_packet_en,
                                int_status, int_enable);
        end else begin
            rd_data <= mwd_pkg::READ_ZERO;
        end
    end

endmodule
